// [logic/eq_fir_pkg.sv]
`default_nettype none
package eq_fir_pkg;

   // ****************************************
   // filter geometry
   // ****************************************
   localparam int NUM_TAPS   = 9;
   localparam int CENTER_TAP = 4;
   localparam int SAMPLE_W   = 12;
   localparam int CENTER_W   = 18;
   localparam int SIDE_W     = 12;
   localparam int ACC_W      = 36;
   localparam int FRAC_BITS  = 16;
   localparam int FIFO_DEPTH = 4;

   // side tap weight: 2^-(10 + sel), sel 0..6
   localparam logic [2:0] SHIFT_MAX = 3'h6;
   localparam logic [2:0] SHIFT_RST = 3'h0;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] COEFF_A_BASE = 8'h40;
   localparam logic [7:0] COEFF_B_BASE = 8'h80;

   // control field positions
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_SHARE_BIT = 2;
   localparam int CTRL_MERGE_BIT = 3;
   localparam int CTRL_LINK_LSB  = 4;
   localparam int CTRL_SHIFT_LSB = 8;
   localparam int STAT_READY_BIT = 8;

   // reset values
   localparam logic [1:0]          MODE_RST  = 2'h0;
   localparam logic [1:0]          LINK_RST  = 2'h0;
   localparam logic [CENTER_W-1:0] COEFF_RST = 18'h0_0000;

   // filter_mode_select values
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ON  = 2'h2;

   // link_mode_select classes
   localparam logic [1:0] LINK_DUAL       = 2'h0;
   localparam logic [1:0] LINK_SINGLE     = 2'h1;
   localparam logic [1:0] LINK_DUAL_INPUT = 2'h2;

   typedef enum logic [1:0] {
      ACT_BYPASS = 2'b00,
      ACT_DUAL   = 2'b01,
      ACT_SINGLE = 2'b10,
      ACT_TVAR   = 2'b11
   } eq_mode_t;

endpackage
`default_nettype wire

// [logic/eq_fir_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module eq_fir_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   // fill side
   input  wire logic             push_valid_i,
   output logic                  push_ready_o,
   input  wire logic [WIDTH-1:0] push_data_i,
   // drain side
   output logic                  pop_valid_o,
   input  wire logic             pop_ready_i,
   output logic [WIDTH-1:0]      pop_data_o
);

   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             push;
   logic             pop;

   // head sits in entry 0 so the output comes straight from a flop
   assign push       = push_valid_i && push_ready_o;
   assign pop        = pop_valid_o && pop_ready_i;
   assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
   assign pop_data_o = mem_reg[0];

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_reg    <= '0;
         pop_valid_o  <= 1'b0;
         push_ready_o <= 1'b1;
      end else begin
         count_reg    <= count_next;
         pop_valid_o  <= (count_next != '0);
         push_ready_o <= (count_next != CNT_W'(DEPTH));
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            mem_reg[i] <= '0;
         end else if (pop) begin
            if (push && (CNT_W'(i + 1) == count_reg)) begin
               mem_reg[i] <= push_data_i;
            end else if (i < DEPTH - 1) begin
               mem_reg[i] <= mem_reg[(i < DEPTH - 1) ? i + 1 : i];
            end
         end else if (push && (CNT_W'(i) == count_reg)) begin
            mem_reg[i] <= push_data_i;
         end
      end
   end

   AST_FIFO_COUNT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (push && !pop) |=> (count_reg == $past(count_reg) + CNT_W'(1)))
      else $error("fifo level did not grow on push");

   AST_FIFO_HEAD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (!pop_valid_o && push) |=> (pop_valid_o && pop_data_o == $past(push_data_i)))
      else $error("fifo head not loaded from push into empty fifo");

endmodule
`default_nettype wire

// [logic/eq_fir_mac.sv]
`timescale 1ns/1ps
`default_nettype none
module eq_fir_mac #(
   parameter int SAMPLE_W = 12
) (
   // taps, newest first
   input  wire logic signed [SAMPLE_W-1:0]            taps_i [eq_fir_pkg::NUM_TAPS],
   input  wire logic        [eq_fir_pkg::CENTER_W-1:0] coef_i [eq_fir_pkg::NUM_TAPS],
   input  wire logic        [2:0]                      shift_i,
   // rounded and saturated result
   output logic signed [SAMPLE_W-1:0]                  y_o
);

   localparam int AW = eq_fir_pkg::ACC_W;
   localparam logic signed [AW-1:0] Y_MAX = AW'((64'sd1 <<< (SAMPLE_W - 1)) - 64'sd1);
   localparam logic signed [AW-1:0] Y_MIN = -Y_MAX - AW'(1);
   localparam logic [eq_fir_pkg::FRAC_BITS-1:0] HALF = 16'h8000;

   logic signed [AW-1:0] acc;
   logic signed [AW-1:0] q;
   logic signed [AW-1:0] r;
   logic [eq_fir_pkg::FRAC_BITS-1:0] frac;

   // full precision sum aligned to 2^-16; rounding only at the output
   always_comb begin
      acc = '0;
      for (int k = 0; k < eq_fir_pkg::NUM_TAPS; k++) begin
         if (k == eq_fir_pkg::CENTER_TAP) begin
            // operands widened first so the product keeps all of its bits
            acc = acc + AW'(taps_i[k]) * AW'($signed(coef_i[k])); // see R5
         end else begin
            acc = acc + ((AW'(taps_i[k]) * AW'($signed(coef_i[k][eq_fir_pkg::SIDE_W-1:0])))
                         <<< (eq_fir_pkg::SHIFT_MAX - shift_i)); // see R6
         end
      end
   end

   // convergent rounding avoids a dc bias on the output
   always_comb begin
      q    = acc >>> eq_fir_pkg::FRAC_BITS;
      frac = acc[eq_fir_pkg::FRAC_BITS-1:0];
      r    = q;
      if (frac > HALF || (frac == HALF && q[0])) begin
         r = q + AW'(1);
      end
      if (r > Y_MAX) begin
         y_o = Y_MAX[SAMPLE_W-1:0];
      end else if (r < Y_MIN) begin
         y_o = Y_MIN[SAMPLE_W-1:0];
      end else begin
         y_o = r[SAMPLE_W-1:0];
      end
   end

endmodule
`default_nettype wire

// [logic/eq_fir_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - enabled filter passes samples through FIR
// R2 - decode mode, sharing and merge settings
// R3 - per-channel mode only in dual link
// R4 - nine independent coefficients per channel
// R5 - center tap 18 bits, LSB 2^-16
// R6 - side taps 12 bits, LSB 2^-10..2^-16
// R7 - one weight setting for all side taps
// R8 - single mode: one filter, interleaved stream
// R9 - time-varying: dual-input link, two sets
// R10 - sets alternate on every successive sample
// R11 - A and B coefficient groups, software writable
// R12 - mode zero forwards samples unchanged
module eq_fir_top #(
   parameter int SAMPLE_W   = eq_fir_pkg::SAMPLE_W,
   parameter int FIFO_DEPTH = eq_fir_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  arst_n_i,
   // avalon-mm register slave
   input  wire logic [7:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [3:0]            avs_byteenable_i,
   input  wire logic [31:0]           avs_writedata_i,
   output logic [31:0]                avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // samples from the converter cores
   input  wire logic                  smp_valid_i,
   output logic                       smp_ready_o,
   input  wire logic [SAMPLE_W-1:0]   smp_a_i,
   input  wire logic [SAMPLE_W-1:0]   smp_b_i,
   // samples to downstream processing
   output logic                       eq_valid_o,
   input  wire logic                  eq_ready_i,
   output logic [SAMPLE_W-1:0]        eq_a_o,
   output logic [SAMPLE_W-1:0]        eq_b_o
);

   localparam int NT = eq_fir_pkg::NUM_TAPS;
   localparam int CW = eq_fir_pkg::CENTER_W;
   localparam int HD = NT - 1;

   // ****************************************
   // declarations
   // ****************************************
   logic [1:0]                mode_reg;
   logic                      share_reg;
   logic                      merge_reg;
   logic [1:0]                link_reg;
   logic [2:0]                shift_reg;
   logic [CW-1:0]             coeff_a_reg [NT];
   logic [CW-1:0]             coeff_b_reg [NT];
   logic signed [SAMPLE_W-1:0] hist_a_reg [HD];
   logic signed [SAMPLE_W-1:0] hist_b_reg [HD];
   logic                      wait_reg;
   eq_fir_pkg::eq_mode_t      act_mode;
   logic                      wr_en;
   logic                      rd_take;
   logic [31:0]               rd_mux;
   logic [31:0]               ctrl_word;
   logic [31:0]               ctrl_next;
   logic [31:0]               be_mask;
   logic                      merged;
   logic signed [SAMPLE_W-1:0] cur_a [NT];
   logic signed [SAMPLE_W-1:0] cur_b [NT];
   logic signed [SAMPLE_W-1:0] win_a [NT];
   logic signed [SAMPLE_W-1:0] win_b [NT];
   logic [CW-1:0]             coef_lane_b [NT];
   logic signed [SAMPLE_W-1:0] y_a;
   logic signed [SAMPLE_W-1:0] y_b;
   logic [SAMPLE_W-1:0]       push_a;
   logic [SAMPLE_W-1:0]       push_b;
   logic                      fifo_ready;
   logic                      accept;

   // ****************************************
   // avalon-mm slave
   // ****************************************
   // every access waits exactly one cycle, so reads see settled data
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_reg <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   assign avs_waitrequest_o = wait_reg;
   assign wr_en   = avs_write_i && !wait_reg;
   assign rd_take = avs_read_i && wait_reg;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         be_mask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
      end
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[eq_fir_pkg::CTRL_MODE_LSB +: 2]  = mode_reg;
      ctrl_word[eq_fir_pkg::CTRL_SHARE_BIT]      = share_reg;
      ctrl_word[eq_fir_pkg::CTRL_MERGE_BIT]      = merge_reg;
      ctrl_word[eq_fir_pkg::CTRL_LINK_LSB +: 2]  = link_reg;
      ctrl_word[eq_fir_pkg::CTRL_SHIFT_LSB +: 3] = shift_reg;
      ctrl_next = (ctrl_word & ~be_mask) | (avs_writedata_i & be_mask);
   end

   always_comb begin
      rd_mux = '0;
      if (avs_address_i == eq_fir_pkg::CTRL_OFS) begin
         rd_mux = ctrl_word;
      end else if (avs_address_i == eq_fir_pkg::STATUS_OFS) begin
         rd_mux[1:0] = act_mode;
         rd_mux[eq_fir_pkg::STAT_READY_BIT] = fifo_ready;
      end else begin
         for (int k = 0; k < NT; k++) begin
            if (avs_address_i == eq_fir_pkg::COEFF_A_BASE + 8'(4 * k)) begin
               rd_mux[CW-1:0] = coeff_a_reg[k];
            end
            if (avs_address_i == eq_fir_pkg::COEFF_B_BASE + 8'(4 * k)) begin
               rd_mux[CW-1:0] = coeff_b_reg[k];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         avs_readdata_o <= '0;
      end else if (rd_take) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_reg  <= eq_fir_pkg::MODE_RST;
         share_reg <= 1'b0;
         merge_reg <= 1'b0;
         link_reg  <= eq_fir_pkg::LINK_RST;
         shift_reg <= eq_fir_pkg::SHIFT_RST;
      end else if (wr_en && avs_address_i == eq_fir_pkg::CTRL_OFS) begin
         mode_reg  <= ctrl_next[eq_fir_pkg::CTRL_MODE_LSB +: 2];
         share_reg <= ctrl_next[eq_fir_pkg::CTRL_SHARE_BIT];
         merge_reg <= ctrl_next[eq_fir_pkg::CTRL_MERGE_BIT];
         link_reg  <= ctrl_next[eq_fir_pkg::CTRL_LINK_LSB +: 2];
         // weights below 2^-16 do not exist; clamp instead of wrapping
         if (ctrl_next[eq_fir_pkg::CTRL_SHIFT_LSB +: 3] > eq_fir_pkg::SHIFT_MAX) begin
            shift_reg <= eq_fir_pkg::SHIFT_MAX; // see R6
         end else begin
            shift_reg <= ctrl_next[eq_fir_pkg::CTRL_SHIFT_LSB +: 3]; // see R7
         end
      end
   end

   // ****************************************
   // coefficient groups
   // ****************************************
   for (genvar k = 0; k < NT; k++) begin : g_coeff
      localparam int VW = (k == eq_fir_pkg::CENTER_TAP) ? CW : eq_fir_pkg::SIDE_W;
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            coeff_a_reg[k] <= eq_fir_pkg::COEFF_RST;
            coeff_b_reg[k] <= eq_fir_pkg::COEFF_RST;
         end else if (wr_en) begin
            if (avs_address_i == eq_fir_pkg::COEFF_A_BASE + 8'(4 * k)) begin
               coeff_a_reg[k] <= CW'((avs_writedata_i[VW-1:0] & be_mask[VW-1:0])
                                 | (coeff_a_reg[k][VW-1:0] & ~be_mask[VW-1:0])); // see R11
            end
            if (avs_address_i == eq_fir_pkg::COEFF_B_BASE + 8'(4 * k)) begin
               coeff_b_reg[k] <= CW'((avs_writedata_i[VW-1:0] & be_mask[VW-1:0])
                                 | (coeff_b_reg[k][VW-1:0] & ~be_mask[VW-1:0])); // see R4
            end
         end
      end
   end

   // ****************************************
   // mode decode
   // ****************************************
   // a setting that the link mode cannot host falls back to bypass
   always_comb begin
      act_mode = eq_fir_pkg::ACT_BYPASS; // see R12
      if (mode_reg == eq_fir_pkg::MODE_ON) begin
         case ({share_reg, merge_reg})
            2'b00: begin
               if (link_reg == eq_fir_pkg::LINK_DUAL) act_mode = eq_fir_pkg::ACT_DUAL; // see R3
            end
            2'b11: begin
               if (link_reg == eq_fir_pkg::LINK_SINGLE) act_mode = eq_fir_pkg::ACT_SINGLE; // see R8
            end
            2'b01: begin
               if (link_reg == eq_fir_pkg::LINK_DUAL_INPUT) act_mode = eq_fir_pkg::ACT_TVAR; // see R9
            end
            default: act_mode = eq_fir_pkg::ACT_BYPASS; // see R2
         endcase
      end
   end

   // ****************************************
   // sample history and tap windows
   // ****************************************
   assign accept = smp_valid_i && fifo_ready;
   assign merged = (act_mode == eq_fir_pkg::ACT_SINGLE) || (act_mode == eq_fir_pkg::ACT_TVAR);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int d = 0; d < HD; d++) begin
            hist_a_reg[d] <= '0;
            hist_b_reg[d] <= '0;
         end
      end else if (accept) begin
         hist_a_reg[0] <= smp_a_i; // see R1
         hist_b_reg[0] <= smp_b_i;
         for (int d = 1; d < HD; d++) begin
            hist_a_reg[d] <= hist_a_reg[d-1];
            hist_b_reg[d] <= hist_b_reg[d-1];
         end
      end
   end

   // lane a is the earlier sample of a beat in the interleaved stream
   always_comb begin
      cur_a[0] = smp_a_i;
      cur_b[0] = smp_b_i;
      for (int d = 1; d < NT; d++) begin
         cur_a[d] = hist_a_reg[d-1];
         cur_b[d] = hist_b_reg[d-1];
      end
      for (int k = 0; k < NT; k++) begin
         if (merged) begin
            win_b[k] = (k % 2 == 0) ? cur_b[k/2] : cur_a[(k-1)/2]; // see R8
            win_a[k] = (k % 2 == 0) ? cur_a[k/2] : cur_b[(k+1)/2];
         end else begin
            win_a[k] = cur_a[k]; // see R3
            win_b[k] = cur_b[k];
         end
         // shared set for single mode, opposite sets per sample otherwise
         coef_lane_b[k] = share_reg ? coeff_a_reg[k] : coeff_b_reg[k]; // see R10
      end
   end

   // ****************************************
   // filter lanes
   // ****************************************
   eq_fir_mac #(
      .SAMPLE_W (SAMPLE_W)
   ) u_mac_a (
      .taps_i  (win_a),
      .coef_i  (coeff_a_reg),
      .shift_i (shift_reg),
      .y_o     (y_a)
   );

   eq_fir_mac #(
      .SAMPLE_W (SAMPLE_W)
   ) u_mac_b (
      .taps_i  (win_b),
      .coef_i  (coef_lane_b),
      .shift_i (shift_reg),
      .y_o     (y_b)
   );

   always_comb begin
      if (act_mode == eq_fir_pkg::ACT_BYPASS) begin
         push_a = smp_a_i; // see R12
         push_b = smp_b_i;
      end else begin
         push_a = y_a; // see R1
         push_b = y_b;
      end
   end

   // ****************************************
   // output buffer
   // ****************************************
   eq_fir_fifo #(
      .WIDTH (2 * SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i    (sys_clk_i),
      .arst_n_i     (arst_n_i),
      .push_valid_i (smp_valid_i),
      .push_ready_o (fifo_ready),
      .push_data_i  ({push_a, push_b}),
      .pop_valid_o  (eq_valid_o),
      .pop_ready_i  (eq_ready_i),
      .pop_data_o   ({eq_a_o, eq_b_o})
   );

   assign smp_ready_o = fifo_ready;

   // ****************************************
   // checks
   // ****************************************
   sequence bus_req_s;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   sequence bus_done_s;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   AST_BUS_ANSWER: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R11
      bus_req_s |=> bus_done_s)
      else $error("bus answer not given after one wait cycle");

   AST_CTRL_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R2
      (wr_en && avs_address_i == eq_fir_pkg::CTRL_OFS && avs_byteenable_i[0])
      |=> (mode_reg == $past(avs_writedata_i[1:0])))
      else $error("mode select not taken from write");

   AST_SHIFT_RANGE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R6
      shift_reg <= eq_fir_pkg::SHIFT_MAX)
      else $error("side tap weight beyond 2^-16");

   AST_CENTER_WRITE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R5
      (wr_en && avs_address_i == eq_fir_pkg::COEFF_A_BASE + 8'h10 && &avs_byteenable_i[2:0])
      |=> (coeff_a_reg[eq_fir_pkg::CENTER_TAP] == $past(avs_writedata_i[CW-1:0])))
      else $error("center tap not stored at 18 bits");

   AST_DUAL_ONLY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R3
      (act_mode == eq_fir_pkg::ACT_DUAL) |-> (link_reg == eq_fir_pkg::LINK_DUAL && !merge_reg))
      else $error("per-channel mode outside dual link");

   AST_TVAR_SETS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R10
      (act_mode == eq_fir_pkg::ACT_TVAR) |-> (coef_lane_b[0] == coeff_b_reg[0] && merged))
      else $error("time-varying mode not alternating coefficient sets");

   AST_BYPASS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R12
      (accept && mode_reg == eq_fir_pkg::MODE_OFF) |-> (push_a == smp_a_i && push_b == smp_b_i))
      else $error("disabled filter altered samples");

   AST_HISTORY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // see R1
      accept ##1 accept |=> (hist_a_reg[1] == $past(smp_a_i, 2)))
      else $error("delay line did not advance");

endmodule
`default_nettype wire

// [verification/eq_fir_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module eq_fir_sink (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   // share of stalled cycles, percent
   input  var int    stall_i,
   // back-pressure towards the filter
   output logic      ready_o
);
   // random stalls so the fifo sees both full and empty
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= ($urandom % 100) >= stall_i;
      end
   end
endmodule
`default_nettype wire

// [verification/programmable_equalizer_fir_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module programmable_equalizer_fir_bench;
   logic        sys_clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic [7:0]  avs_address_i = '0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = '0;
   logic [3:0]  be = 4'hF;
   logic [31:0] avs_readdata_o;
   logic [31:0] rd;
   logic        avs_waitrequest_o;
   logic        smp_valid_i = 1'b0;
   logic        smp_ready_o;
   logic        eq_valid_o;
   logic        eq_ready_i;
   logic [11:0] smp_a_i = '0;
   logic [11:0] smp_b_i = '0;
   logic [11:0] eq_a_o;
   logic [11:0] eq_b_o;
   int          n_fail = 0;
   int          total_checks = 0;
   int          stall = 0;
   int          ca[9];
   int          cb[9];
   int          ha[10] = '{default: 0};
   int          hb[10] = '{default: 0};
   logic [23:0] expq[$];
   int          cfg[8] = '{32'h30C, 32'h002, 32'h61E, 32'h72A, 32'h012, 32'h00E, 32'h01A, 32'h101};
   int          act[8] = '{0, 1, 2, 3, 0, 0, 0, 0};

   always #20 sys_clk_i = ~sys_clk_i;

   eq_fir_top #(.SAMPLE_W(12), .FIFO_DEPTH(4)) i_dut (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_byteenable_i(be), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o), .smp_a_i(smp_a_i), .smp_b_i(smp_b_i),
      .eq_valid_o(eq_valid_o), .eq_ready_i(eq_ready_i), .eq_a_o(eq_a_o), .eq_b_o(eq_b_o));

   eq_fir_sink i_sink (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .stall_i(stall), .ready_o(eq_ready_i));

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
      total_checks++;
      if (got !== want) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask

   // ****************************************
   // bus and stream drivers
   // ****************************************
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (i == 20) begin
         chk(0, 1, "bus timeout");
         finish_test();
      end
   endtask

   // reference: full precision sum in 2^-16 units, round half to even
   function automatic int fir(int x[10], int c[9], int sel);
      longint acc;
      longint q;
      acc = 0;
      for (int k = 0; k < 9; k++) acc += longint'(x[k]) * (k == 4 ? c[k] : c[k] <<< (6 - sel));
      q = acc >>> 16;
      if (acc - (q <<< 16) > 32768 || (acc - (q <<< 16) == 32768 && q[0])) q++;
      return q > 2047 ? 2047 : (q < -2048 ? -2048 : int'(q));
   endfunction

   // holds valid up between calls so bursts run back to back
   task automatic push(input int md, input int sel);
      logic [11:0] a;
      logic [11:0] b;
      int i, ea, eb, ta[10], tb[10];
      a = 12'($urandom);
      b = 12'($urandom);
      smp_valid_i <= 1'b1;
      smp_a_i <= a;
      smp_b_i <= b;
      for (i = 0; i < 60; i++) begin
         @(posedge sys_clk_i);
         if (smp_ready_o === 1'b1) break;
      end
      if (i == 60) begin
         chk(0, 1, "push timeout");
         finish_test();
      end
      for (i = 9; i > 0; i--) begin
         ha[i] = ha[i-1];
         hb[i] = hb[i-1];
      end
      ha[0] = int'($signed(a));
      hb[0] = int'($signed(b));
      // interleaved stream: lane a is the earlier sample of each pair
      for (i = 0; i < 9; i++) begin
         ta[i] = md == 1 ? ha[i] : (i % 2 == 0 ? ha[i/2] : hb[(i+1)/2]);
         tb[i] = md == 1 ? hb[i] : (i % 2 == 0 ? hb[i/2] : ha[(i-1)/2]);
      end
      ea = md == 0 ? int'(a) : fir(ta, ca, sel);
      eb = md == 0 ? int'(b) : fir(tb, md == 2 ? ca : cb, sel);
      expq.push_back({ea[11:0], eb[11:0]});
   endtask

   task automatic drain;
      for (int i = 0; i < 600 && expq.size() > 0; i++) @(posedge sys_clk_i);
      if (expq.size() > 0) begin
         chk(0, 1, "drain timeout");
         finish_test();
      end
   endtask

   always @(posedge sys_clk_i) begin
      if (arst_n_i && eq_valid_o === 1'b1 && eq_ready_i === 1'b1) begin
         if (expq.size() == 0) begin
            chk(0, 1, "unexpected output");
         end else begin
            chk({8'h00, eq_a_o, eq_b_o}, expq.pop_front(), "sample");
         end
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int m, sel, c;
      void'($urandom(32'h0a64));
      repeat (4) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      bus(0, eq_fir_pkg::CTRL_OFS, 0);
      chk(rd, 32'h0000_0000, "ctrl reset");
      bus(0, eq_fir_pkg::STATUS_OFS, 0);
      chk(rd, 32'h0000_0100, "status reset");
      bus(1, 8'h3C, 32'hFFFF_FFFF);
      bus(0, 8'h3C, 0);
      chk(rd, 32'h0000_0000, "unmapped");
      // byte lane 1 only: the weight field clamps, the mode byte stays put
      be <= 4'h2;
      bus(1, eq_fir_pkg::CTRL_OFS, 32'hFFFF_FFFF);
      be <= 4'hF;
      bus(0, eq_fir_pkg::CTRL_OFS, 0);
      chk(rd, 32'h0000_0600, "byte lane write");
      for (int k = 0; k < 9; k++) begin
         m = k == 4 ? 32'h0003_FFFF : 32'h0000_0FFF;
         ca[k] = k == 4 ? 57344 + int'($urandom % 16384) : int'($urandom % 512) - 256;
         cb[k] = k == 4 ? 57344 + int'($urandom % 16384) : int'($urandom % 512) - 256;
         bus(1, eq_fir_pkg::COEFF_A_BASE + 8'(4 * k), ca[k] & m);
         bus(1, eq_fir_pkg::COEFF_B_BASE + 8'(4 * k), cb[k] & m);
      end
      for (int k = 0; k < 9; k++) begin
         m = k == 4 ? 32'h0003_FFFF : 32'h0000_0FFF;
         bus(0, eq_fir_pkg::COEFF_A_BASE + 8'(4 * k), 0);
         chk(rd, ca[k] & m, "coeff a");
         bus(0, eq_fir_pkg::COEFF_B_BASE + 8'(4 * k), 0);
         chk(rd, cb[k] & m, "coeff b");
      end
      // fill the fifo with the sink stalled, then release it
      stall = 100;
      repeat (3) @(posedge sys_clk_i);
      repeat (4) push(0, 0);
      smp_valid_i <= 1'b0;
      @(posedge sys_clk_i);
      chk(smp_ready_o, 0, "fifo full ready");
      bus(0, eq_fir_pkg::STATUS_OFS, 0);
      chk(rd, 32'h0000_0000, "status full");
      stall = 0;
      drain();
      for (int j = 0; j < 8; j++) begin
         c = cfg[j];
         sel = (c >> 8) & 7;
         sel = sel > 6 ? 6 : sel;
         bus(1, eq_fir_pkg::CTRL_OFS, c);
         bus(0, eq_fir_pkg::CTRL_OFS, 0);
         chk(rd, (c & 32'hFFFF_F8FF) | (sel << 8), "ctrl readback");
         bus(0, eq_fir_pkg::STATUS_OFS, 0);
         chk(rd, 32'h0000_0100 | act[j], "active mode");
         stall = 30;
         repeat (40) push(act[j], sel);
         smp_valid_i <= 1'b0;
         drain();
      end
      finish_test();
   end
endmodule
`default_nettype wire
